//--- design/nvm_port_pkg.sv
/*
 * Types for the parallel programming port.
 * Assumes the constants header sits beside it.
 */
`include "nvm_port_regs.svh"
`default_nettype none

package nvm_port_pkg;
	// Programming sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_BUSY  = 3'b010,
		ST_LATCH = 3'b100
	} prog_state_t;
endpackage

`default_nettype wire

//--- design/nvm_port_regs.svh
/*
 * Constants for the parallel programming port: command codes, action
 * select codes, memory geometry and self-timed write durations.
 * Assumes inclusion by bare name from the package and the design.
 */
`ifndef NVM_PORT_REGS_SVH
`define NVM_PORT_REGS_SVH

// Command byte codes
`define CMD_NOP        8'h00
`define CMD_CHIP_ERASE 8'h80
`define CMD_WR_FUSE    8'h40
`define CMD_WR_LOCK    8'h20
`define CMD_WR_FLASH   8'h10
`define CMD_WR_EEPROM  8'h11
`define CMD_RD_SIG     8'h08
`define CMD_RD_FUSE    8'h04
`define CMD_RD_FLASH   8'h02
`define CMD_RD_EEPROM  8'h03

// Action select codes {hi,lo}
`define ACT_ADDR 2'h0
`define ACT_DATA 2'h1
`define ACT_CMD  2'h2
`define ACT_IDLE 2'h3

// Geometry: flash words per page bits, eeprom bytes per page bits
`define FLASH_WORD_BITS   6
`define FLASH_ADDR_BITS   13
`define EE_WORD_BITS      2
`define EE_ADDR_BITS      9

// Self-timed write times in microseconds, clock rate in MHz
`define CLK_MHZ           125
`define T_FLASH_US        4500
`define T_EEPROM_US       9000
`define T_FUSE_US         4500
`define T_ERASE_US        9000

// Reset values of fuses and locks (erased)
`define FUSE_LO_RST 8'hff
`define FUSE_HI_RST 8'hff
`define LOCK_RST    8'hff

`endif

//--- design/nvm_prog_port.sv
/*
 * Parallel high-voltage programming port: strobe-driven loading of
 * command, address and data, page buffers, self-timed writes of flash,
 * eeprom, fuses and locks, and readback on a three-signal data bus.
 * Assumes all pins are asynchronous to clk_i and pulses last >= 250 ns.
 */
`include "nvm_port_regs.svh"
`default_nettype none

module nvm_prog_port
	import nvm_port_pkg::*;
#(
	parameter int  FLASH_CYC  = `T_FLASH_US * `CLK_MHZ,
	parameter int  EEPROM_CYC = `T_EEPROM_US * `CLK_MHZ,
	parameter int  FUSE_CYC   = `T_FUSE_US * `CLK_MHZ,
	parameter int  ERASE_CYC  = `T_ERASE_US * `CLK_MHZ,
	parameter logic [7:0] SIG0 = 8'h11, // Arbitrary identity value
	parameter logic [7:0] SIG1 = 8'h22, // Arbitrary identity value
	parameter logic [7:0] SIG2 = 8'h33, // Arbitrary identity value
	parameter logic [7:0] CALIB = 8'h80
) (
	// Clock, reset, enable
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       ce_i,
	// Programmer strobes and selects
	input  wire logic       load_strobe_clock_i,
	input  wire logic       strobe_action_hi_i,
	input  wire logic       strobe_action_lo_i,
	input  wire logic       byte_select_primary_i,
	input  wire logic       byte_select_secondary_i,
	input  wire logic       page_latch_strobe_i,
	input  wire logic       write_n_i,
	input  wire logic       out_enable_n_i,
	// Data bus
	input  wire logic [7:0] data_i,
	output logic      [7:0] data_o,
	output logic            data_oe_o,
	// Status
	output logic            ready_busy_flag_o
);

	localparam int FW = 1 << `FLASH_WORD_BITS;
	localparam int EW = 1 << `EE_WORD_BITS;
	localparam int FA = `FLASH_ADDR_BITS;
	localparam int EA = `EE_ADDR_BITS;

	////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers
	logic [1:0] rst_sync_r;
	logic       rst_n;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// Control pins and data: two stages each, stage one read only by two
	localparam int NP = 16;
	logic [NP-1:0] pin_raw;
	logic [NP-1:0] s1_r;
	logic [NP-1:0] s2_r;
	logic [NP-1:0] s3_r; // Previous value for edge detection

	assign pin_raw = {data_i, load_strobe_clock_i, strobe_action_hi_i,
		strobe_action_lo_i, byte_select_primary_i,
		byte_select_secondary_i, page_latch_strobe_i, write_n_i,
		out_enable_n_i};

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= 16'h00ff;
			s2_r <= 16'h00ff;
			s3_r <= 16'h00ff;
		end else if (ce_i) begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	logic [7:0] din;
	logic       xt_rise;
	logic [1:0] act;
	logic       bs1;
	logic       bs2;
	logic       pl_rise;
	logic       wr_fall;
	logic       oe_n;

	assign din     = s2_r[15:8];
	assign xt_rise = s2_r[7] & ~s3_r[7];
	assign act     = s2_r[6:5];
	assign bs1     = s2_r[4];
	assign bs2     = s2_r[3];
	assign pl_rise = s2_r[2] & ~s3_r[2];
	assign wr_fall = ~s2_r[1] & s3_r[1];
	assign oe_n    = s2_r[0];

	////////////////////////////////////////////////////////////////////
	// Loaded command, address, data; held until overwritten
	logic [7:0] cmd_r, cmd_nxt;
	logic [7:0] adl_r, adl_nxt;
	logic [7:0] adh_r, adh_nxt;
	logic [7:0] dl_r,  dl_nxt;
	logic [7:0] dh_r,  dh_nxt;
	logic       wr_arm_r, wr_arm_nxt; // Internal write signal

	always_comb begin
		cmd_nxt    = cmd_r;
		adl_nxt    = adl_r;
		adh_nxt    = adh_r;
		dl_nxt     = dl_r;
		dh_nxt     = dh_r;
		wr_arm_nxt = wr_arm_r;
		if (xt_rise) begin
			unique case (act)
				`ACT_ADDR: begin
					if (bs1)
						adh_nxt = din;
					else
						adl_nxt = din;
				end
				`ACT_DATA: begin
					if (bs1)
						dh_nxt = din;
					else
						dl_nxt = din;
				end
				`ACT_CMD: begin
					cmd_nxt    = din;
					wr_arm_nxt = (din != `CMD_NOP);
				end
				`ACT_IDLE: ;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cmd_r    <= 8'h00;
			adl_r    <= 8'h00;
			adh_r    <= 8'h00;
			dl_r     <= 8'h00;
			dh_r     <= 8'h00;
			wr_arm_r <= 1'b0;
		end else if (ce_i) begin
			cmd_r    <= cmd_nxt;
			adl_r    <= adl_nxt;
			adh_r    <= adh_nxt;
			dl_r     <= dl_nxt;
			dh_r     <= dh_nxt;
			wr_arm_r <= wr_arm_nxt;
		end
	end

	// Full word addresses; page part includes upper low-byte bits
	logic [FA-1:0] faddr;
	logic [EA-1:0] eaddr;
	assign faddr = FA'({adh_r, adl_r});
	assign eaddr = EA'({adh_r, adl_r});

	////////////////////////////////////////////////////////////////////
	// Memories, page buffers and nonvolatile bits
	logic [15:0] flash_mem [0:(1<<FA)-1];
	logic [7:0]  ee_mem    [0:(1<<EA)-1];
	logic [15:0] fbuf      [0:FW-1];
	logic [7:0]  ebuf      [0:EW-1];
	logic [7:0]  fuse_lo_r;
	logic [7:0]  fuse_hi_r;
	logic [7:0]  lock_r;

	prog_state_t st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [7:0]  op_r, op_nxt;   // Command being executed
	logic        sel_r, sel_nxt; // High-fuse select captured at start
	logic        commit;         // Final cycle of a self-timed write

	// Sequencer: a write pulse starts a timed operation; busy holds off
	// further pulses so a page cannot be overwritten mid-program
	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r;
		op_nxt  = op_r;
		sel_nxt = sel_r;
		commit  = 1'b0;
		unique case (st_r)
			ST_IDLE: begin
				if (wr_fall && wr_arm_r && !bs2) begin
					op_nxt  = cmd_r;
					sel_nxt = bs1;
					st_nxt  = ST_BUSY;
					unique case (cmd_r)
						`CMD_WR_FLASH: cnt_nxt = FLASH_CYC;
						`CMD_WR_EEPROM: cnt_nxt = EEPROM_CYC;
						`CMD_CHIP_ERASE: cnt_nxt = ERASE_CYC;
						`CMD_WR_FUSE,
						`CMD_WR_LOCK: cnt_nxt = FUSE_CYC;
						default: st_nxt = ST_IDLE;
					endcase
					if ((cmd_r == `CMD_WR_FLASH ||
						cmd_r == `CMD_WR_EEPROM) && bs1)
						st_nxt = ST_IDLE; // Page write needs select low
				end
			end
			ST_BUSY: begin
				if (cnt_r <= 32'h1)
					st_nxt = ST_LATCH;
				else
					cnt_nxt = cnt_r - 32'h1;
			end
			ST_LATCH: begin
				commit = 1'b1;
				st_nxt = ST_IDLE;
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_r  <= ST_IDLE;
			cnt_r <= 32'h0;
			op_r  <= 8'h00;
			sel_r <= 1'b0;
		end else if (ce_i) begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
			op_r  <= op_nxt;
			sel_r <= sel_nxt;
		end
	end

	// Busy whenever a timed operation runs
	assign ready_busy_flag_o = (st_r == ST_IDLE);

	// Nonvolatile bits: zero programs, fuses may erase, locks only by chip erase
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fuse_lo_r <= `FUSE_LO_RST;
			fuse_hi_r <= `FUSE_HI_RST;
			lock_r    <= `LOCK_RST;
		end else if (ce_i && commit) begin
			if (op_r == `CMD_WR_FUSE && !sel_r)
				fuse_lo_r <= dl_r;
			if (op_r == `CMD_WR_FUSE && sel_r)
				fuse_hi_r <= dl_r;
			if (op_r == `CMD_WR_LOCK)
				lock_r <= lock_r & dl_r;
			if (op_r == `CMD_CHIP_ERASE)
				lock_r <= `LOCK_RST;
		end
	end

	// Page buffers fill on page latch; arrays take whole pages on commit.
	// Arrays are not reset: they model storage contents.
	always_ff @(posedge clk_i) begin
		if (ce_i && rst_n) begin
			if (pl_rise && bs1 && st_r == ST_IDLE) begin
				if (cmd_r == `CMD_WR_FLASH)
					fbuf[adl_r[`FLASH_WORD_BITS-1:0]] <= {dh_r, dl_r};
				if (cmd_r == `CMD_WR_EEPROM)
					ebuf[adl_r[`EE_WORD_BITS-1:0]] <= dl_r;
			end
			if (commit && op_r == `CMD_WR_FLASH) begin
				for (int i = 0; i < FW; i++)
					flash_mem[{faddr[FA-1:`FLASH_WORD_BITS],
						`FLASH_WORD_BITS'(i)}] <= fbuf[i];
			end
			if (commit && op_r == `CMD_WR_EEPROM) begin
				for (int i = 0; i < EW; i++)
					ee_mem[{eaddr[EA-1:`EE_WORD_BITS],
						`EE_WORD_BITS'(i)}] <= ebuf[i];
			end
			if (commit && op_r == `CMD_CHIP_ERASE) begin
				for (int i = 0; i < (1 << FA); i++)
					flash_mem[i] <= 16'hffff;
				for (int i = 0; i < (1 << EA); i++)
					ee_mem[i] <= 8'hff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Readback mux, registered onto the bus
	logic [7:0] rd_nxt;
	logic [7:0] rd_r;
	logic       oe_r;
	logic [15:0] fword;
	assign fword = flash_mem[faddr];

	always_comb begin
		rd_nxt = 8'h00;
		unique case (cmd_r)
			`CMD_RD_FLASH: rd_nxt = bs1 ? fword[15:8] : fword[7:0];
			`CMD_RD_EEPROM: rd_nxt = ee_mem[eaddr];
			`CMD_RD_FUSE: begin
				if (!bs1 && !bs2)
					rd_nxt = fuse_lo_r;
				else if (bs1 && bs2)
					rd_nxt = fuse_hi_r;
				else if (bs1)
					rd_nxt = lock_r;
			end
			`CMD_RD_SIG: begin
				if (bs1)
					rd_nxt = (adl_r == 8'h00) ? CALIB : 8'h00;
				else if (adl_r == 8'h00)
					rd_nxt = SIG0;
				else if (adl_r == 8'h01)
					rd_nxt = SIG1;
				else if (adl_r == 8'h02)
					rd_nxt = SIG2;
			end
			default: rd_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rd_r <= 8'h00;
			oe_r <= 1'b0;
		end else if (ce_i) begin
			rd_r <= rd_nxt;
			oe_r <= ~oe_n;
		end
	end

	assign data_o    = rd_r;
	assign data_oe_o = oe_r;

endmodule

`default_nettype wire

//--- verif/nvm_port_asserts.sv
/*
 * Checker for the parallel programming port, bound into the top module.
 * Assumes pins are held at least six clocks, as the programmer model does.
 */
`default_nettype none

module nvm_port_checker #(
	parameter int CYC = 20
) (
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       arst_n_i,
	// Watched pins
	input wire logic       load_strobe_clock_i,
	input wire logic       byte_select_primary_i,
	input wire logic       byte_select_secondary_i,
	input wire logic       write_n_i,
	input wire logic       out_enable_n_i,
	input wire logic [7:0] data_o,
	input wire logic       data_oe_o,
	input wire logic       ready_busy_flag_o
);
	localparam int BUSY_HI = CYC + 8;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	////////////////////////////////////////////////////////////////////////
	// Busy period: caused by a write pulse, long enough, and bounded
	busy_hold_a: assert property (
		$fell(ready_busy_flag_o) |-> (!ready_busy_flag_o)[*8])
		else $error("busy shorter than eight clocks");
	busy_bound_a: assert property (
		!ready_busy_flag_o |-> ##[1:BUSY_HI] ready_busy_flag_o)
		else $error("busy never ends");
	busy_cause_a: assert property (
		$fell(ready_busy_flag_o) |-> !$past(write_n_i, 3))
		else $error("busy without a write pulse");
	busy_length_a: assert property (
		$rose(ready_busy_flag_o) |-> !$past(ready_busy_flag_o, CYC))
		else $error("busy period too short");
	no_write_idle_a: assert property (
		ready_busy_flag_o && write_n_i[*6] |=> ready_busy_flag_o)
		else $error("busy without any write");

	////////////////////////////////////////////////////////////////////////
	// Data bus ownership and read stability
	bus_release_a: assert property (
		out_enable_n_i[*5] |-> !data_oe_o)
		else $error("bus driven with output enable high");
	drive_cause_a: assert property (
		$rose(data_oe_o) |-> !out_enable_n_i)
		else $error("bus driven without output enable");
	read_steady_a: assert property (
		(data_oe_o && $stable(byte_select_primary_i)
		&& $stable(byte_select_secondary_i) && $stable(out_enable_n_i)
		&& $stable(load_strobe_clock_i))[*6] |=> $stable(data_o))
		else $error("read data moved with steady selects");
endmodule

bind nvm_prog_port nvm_port_checker #(.CYC(FLASH_CYC)) chk (
	.clk_i(clk_i), .arst_n_i(arst_n_i),
	.load_strobe_clock_i(load_strobe_clock_i),
	.byte_select_primary_i(byte_select_primary_i),
	.byte_select_secondary_i(byte_select_secondary_i),
	.write_n_i(write_n_i), .out_enable_n_i(out_enable_n_i),
	.data_o(data_o), .data_oe_o(data_oe_o),
	.ready_busy_flag_o(ready_busy_flag_o)
);

`default_nettype wire

//--- verif/nvm_programmer.sv
/*
 * Model of the external parallel programmer driving the port's pins.
 * Assumes its tasks are called from the bench; pins change on clk_i.
 */
`default_nettype none

module nvm_programmer (
	// Clock, status and bus as seen by the programmer
	input  wire logic       clk_i,
	input  wire logic       ready_i,
	input  wire logic [7:0] bus_i,
	// Pins: strobe, action hi/lo, selects, page latch, write_n, oe_n
	output logic      [7:0] pins_o,
	output logic      [7:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle pins; levels held eight clocks so the synchronisers see them
	initial begin
		pins_o = 8'h63;
		data_o = 8'h00;
	end

	task automatic put(input logic [7:0] p, input logic [7:0] d);
		pins_o <= p;
		data_o <= d;
		repeat (8) @(posedge clk_i);
	endtask

	// Strobe one byte under an action code
	task automatic load(input logic [1:0] a, input logic b,
		input logic [7:0] d);
		put({1'b0, a, b, 4'h3}, d);
		put({1'b1, a, b, 4'h3}, d);
		put({1'b0, 2'h3, b, 4'h3}, d);
	endtask

	// Page latch pulse with primary select high
	task automatic latch();
		put(8'h77, data_o);
		put(8'h73, data_o);
	endtask

	task automatic write(input logic b1, input logic b2);
		put({3'h3, b1, b2, 3'h1}, data_o);
		put({3'h3, b1, b2, 3'h3}, data_o);
	endtask

	// Bounded wait; never starts a new page while busy
	task automatic wait_ready();
		for (int i = 0; i < 400 && ready_i !== 1'b1; i++) begin
			@(posedge clk_i);
		end
	endtask

	// Released bus shows the inverse of the last value
	task automatic read(input logic b1, input logic b2,
		output logic [7:0] q);
		put({3'h3, b1, b2, 3'h2}, ~data_o);
		q = bus_i;
		put({3'h3, b1, b2, 3'h3}, data_o);
	endtask
endmodule

`default_nettype wire

//--- verif/parallel_nvm_programming_port_tb.sv
/*
 * Bench: fuses, locks, flash and eeprom pages, signature reads.
 * Assumes short busy counts; the programmer model drives all pins.
 */
`include "nvm_port_regs.svh"
`default_nettype none

module parallel_nvm_programming_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CYC = 20;
	// Arbitrary identity values
	localparam logic [7:0] SIG [4] = '{8'h5e, 8'h6d, 8'h7c, 8'h9b};
	logic       clk_i;
	logic       arst_n_i;
	logic       rdy;
	logic       doe;
	logic [7:0] pins;
	logic [7:0] pdat;
	logic [7:0] ddat;
	logic [7:0] bus;
	logic [7:0] q;
	int         failures = 0;
	int         compares = 0;
	int         cycles = 0;

	assign bus = doe ? ddat : pdat;

	nvm_prog_port #(.FLASH_CYC(CYC), .EEPROM_CYC(CYC), .FUSE_CYC(CYC),
		.ERASE_CYC(CYC), .SIG0(SIG[0]), .SIG1(SIG[1]), .SIG2(SIG[2]),
		.CALIB(SIG[3])) uut (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
		.load_strobe_clock_i(pins[7]), .strobe_action_hi_i(pins[6]),
		.strobe_action_lo_i(pins[5]), .byte_select_primary_i(pins[4]),
		.byte_select_secondary_i(pins[3]), .page_latch_strobe_i(pins[2]),
		.write_n_i(pins[1]), .out_enable_n_i(pins[0]), .data_i(bus),
		.data_o(ddat), .data_oe_o(doe), .ready_busy_flag_o(rdy));

	nvm_programmer prog (.clk_i(clk_i), .ready_i(rdy), .bus_i(bus),
		.pins_o(pins), .data_o(pdat));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic print_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic b1, input logic b2, input logic [7:0] e);
		prog.read(b1, b2, q);
		check(q, e);
		check({7'h0, doe}, 8'h00);
	endtask

	task automatic wr(input logic b1, input logic b2);
		prog.write(b1, b2);
		prog.wait_ready();
		check({7'h0, rdy}, 8'h01);
	endtask

	// Hang guard; the full run needs about 1600 clocks
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 20000) begin
			failures++;
			$display("mismatch at %0t: timeout", $time);
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		arst_n_i = 1'b0;
		repeat (10) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		check({7'h0, rdy}, 8'h01);
		prog.load(`ACT_CMD, 1'b0, `CMD_WR_FUSE);
		prog.load(`ACT_DATA, 1'b0, 8'ha5);
		wr(1'b0, 1'b0);
		prog.load(`ACT_DATA, 1'b0, 8'h5a);
		wr(1'b1, 1'b0);
		prog.load(`ACT_CMD, 1'b0, `CMD_WR_LOCK);
		prog.load(`ACT_DATA, 1'b0, 8'hf0);
		wr(1'b0, 1'b0);
		prog.load(`ACT_DATA, 1'b0, 8'h3c);
		wr(1'b0, 1'b0);
		prog.load(`ACT_CMD, 1'b0, `CMD_RD_FUSE);
		rd(1'b0, 1'b0, 8'ha5);
		rd(1'b1, 1'b1, 8'h5a);
		rd(1'b1, 1'b0, 8'h30);
		// Two flash words in page five, then a write refused after no-op
		prog.load(`ACT_CMD, 1'b0, `CMD_WR_FLASH);
		prog.load(`ACT_ADDR, 1'b1, 8'h01);
		for (int w = 0; w < 2; w++) begin
			prog.load(`ACT_ADDR, 1'b0, 8'h40 + 8'(w));
			prog.load(`ACT_DATA, 1'b0, 8'h10 + 8'(w));
			prog.load(`ACT_DATA, 1'b1, 8'hc0 + 8'(w));
			prog.latch();
		end
		wr(1'b0, 1'b0);
		prog.load(`ACT_CMD, 1'b0, `CMD_NOP);
		prog.write(1'b0, 1'b0);
		check({7'h0, rdy}, 8'h01);
		prog.load(`ACT_CMD, 1'b0, `CMD_RD_FLASH);
		for (int w = 0; w < 2; w++) begin
			prog.load(`ACT_ADDR, 1'b0, 8'h40 + 8'(w));
			rd(1'b0, 1'b0, 8'h10 + 8'(w));
			rd(1'b1, 1'b0, 8'hc0 + 8'(w));
		end
		// Full eeprom page of four bytes, high address kept
		prog.load(`ACT_CMD, 1'b0, `CMD_WR_EEPROM);
		for (int b = 0; b < 4; b++) begin
			prog.load(`ACT_ADDR, 1'b0, 8'h04 + 8'(b));
			prog.load(`ACT_DATA, 1'b0, 8'h60 + 8'(b));
			prog.latch();
		end
		wr(1'b0, 1'b0);
		prog.load(`ACT_CMD, 1'b0, `CMD_RD_EEPROM);
		for (int b = 0; b < 4; b++) begin
			prog.load(`ACT_ADDR, 1'b0, 8'h04 + 8'(b));
			rd(1'b0, 1'b0, 8'h60 + 8'(b));
		end
		// Signature bytes, then calibration at address zero
		prog.load(`ACT_CMD, 1'b0, `CMD_RD_SIG);
		for (int s = 0; s < 3; s++) begin
			prog.load(`ACT_ADDR, 1'b0, 8'(s));
			rd(1'b0, 1'b0, SIG[s]);
		end
		prog.load(`ACT_ADDR, 1'b0, 8'h00);
		rd(1'b1, 1'b0, SIG[3]);
		// Chip erase clears locks and eeprom, fuses stay as written
		prog.load(`ACT_CMD, 1'b0, `CMD_CHIP_ERASE);
		wr(1'b0, 1'b0);
		prog.load(`ACT_CMD, 1'b0, `CMD_RD_FUSE);
		rd(1'b1, 1'b0, `LOCK_RST);
		rd(1'b0, 1'b0, 8'ha5);
		prog.load(`ACT_CMD, 1'b0, `CMD_RD_EEPROM);
		rd(1'b0, 1'b0, 8'hff);
		print_verdict();
	end
endmodule

`default_nettype wire
